// *** verilog/mcs_pkg.sv ***
package mcs_pkg;

  // Clock
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CLK_NS           = 50;
  localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;

  // Timing
  localparam int unsigned T_RESET_MIN_NS   = 10_000;
  localparam int unsigned RESET_MIN_CYCLES = (T_RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_INIT_US        = 2000;
  localparam int unsigned INIT_CYCLES      = T_INIT_US * CYC_PER_US;
  localparam int unsigned T_CLEAR_MAX_US   = 500;
  localparam int unsigned CLEAR_MAX_CYCLES = T_CLEAR_MAX_US * CYC_PER_US;

  // Flag vector
  localparam int unsigned NUM_FLAGS_DEF    = 8;
  localparam int unsigned FLAG_RX_LOSS_BIT = 0;

  // Register offsets
  localparam int unsigned WB_ADDR_W        = 8;
  localparam logic [7:0]  ADDR_STATUS      = 8'h00;
  localparam logic [7:0]  ADDR_FLAGS       = 8'h04;
  localparam logic [7:0]  ADDR_FLAG_MASK   = 8'h08;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h14;

  // Field positions
  localparam int unsigned STAT_NOT_READY   = 0;
  localparam int unsigned STAT_LOW_POWER   = 1;
  localparam int unsigned STAT_RESPOND     = 2;
  localparam int unsigned STAT_READY_FLAG  = 3;
  localparam int unsigned CTRL_PDOWN       = 0;
  localparam int unsigned IRQ_W            = 4;
  localparam int unsigned IRQ_READY        = 0;
  localparam int unsigned IRQ_FLAG         = 1;
  localparam int unsigned IRQ_MOD_RESET    = 2;
  localparam int unsigned IRQ_SERIAL_END   = 3;

  // Reset values
  localparam logic [7:0]       FLAG_MASK_RST = 8'h00;
  localparam logic             CTRL_PDOWN_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 4'h0;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_INIT,
    ST_READY
  } mcs_state_t;

endpackage

// *** verilog/mcs_wire_watch.sv ***
`timescale 1ns/1ns
module mcs_wire_watch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bus gate
  input  wire logic enable,
  // Serial lines
  input  wire logic scl,
  input  wire logic sda,
  // Timing reference
  output logic      refEdge,
  output logic      refRead
);
  import mcs_pkg::*;

  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       inFrame_r;
  logic       armed_r;
  logic       rw_r;
  logic [3:0] bitCnt_r;
  logic       startCond;
  logic       stopCond;
  logic       sclRise;
  logic       sclFall;

  assign startCond = sclPrev_r && scl && sdaPrev_r && !sda;
  assign stopCond  = sclPrev_r && scl && !sdaPrev_r && sda;
  assign sclRise   = !sclPrev_r && scl;
  assign sclFall   = sclPrev_r && !scl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
    end
  end

  // Frame tracking, direction bit is the eighth bit of the address byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inFrame_r <= 1'b0;
      armed_r   <= 1'b0;
      rw_r      <= 1'b0;
      bitCnt_r  <= 4'h0;
    end else if (!enable) begin
      inFrame_r <= 1'b0;
      armed_r   <= 1'b0;
    end else if (startCond) begin
      inFrame_r <= 1'b1;
      bitCnt_r  <= 4'h0;
    end else if (stopCond) begin
      inFrame_r <= 1'b0;
      armed_r   <= inFrame_r;
    end else begin
      if (sclFall) begin
        armed_r <= 1'b0;
      end
      if (sclRise && inFrame_r && bitCnt_r != 4'h8) begin
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == 4'h7) begin
          rw_r <= sda;
        end
      end
    end
  end

  // First falling clock edge after the stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refEdge <= 1'b0;
      refRead <= 1'b0;
    end else begin
      refEdge <= enable && armed_r && sclFall; // [R13]
      refRead <= rw_r;
    end
  end

  sequence s_stopSeen;
    enable && inFrame_r && stopCond;
  endsequence

  property p_refAfterStop;
    @(posedge clk) disable iff (!rst_n)
    s_stopSeen ##1 (enable && scl)[*3] ##1 (enable && sclFall) |=> refEdge && refRead == $past(rw_r);
  endproperty
  a_refAfterStop: assert property (p_refAfterStop) else $error("no reference edge after stop"); // [R13]

endmodule

// *** verilog/mcs_control_status.sv ***
// Contract
// R1 - A low level on module_reset_n lasting past the least reset pulse time resets the module.
// R2 - After power on the module clears data-not-ready and asserts module_interrupt_n once ready.
// R3 - Fully functional means data-not-ready, status bit 0, cleared with module_interrupt_n asserted.
// R4 - After module_reset_n rises the module initialises and reaches the fully functional state.
// R5 - The module answers on the serial bus only after it has come up from power on.
// R6 - Asserting low_power_select takes the module to the lower power level.
// R7 - A flag condition sets its flag bit and drives module_interrupt_n low.
// R8 - Entering receive signal loss sets the rx_signal_loss flag and asserts module_interrupt_n.
// R9 - Reading flags clears them and module_interrupt_n releases within 500 us.
// R10 - A set mask bit keeps its flag off module_interrupt_n, a cleared one restores it.
// R11 - The serial bus is answered only while module_select_n is asserted.
// R12 - The power-down control bit moves the module to low power, clearing it returns to full function.
// R13 - Delays after a serial transaction count from the falling clock edge after its stop.
// R14 - After module_interrupt_n asserts the host reads the flag bytes to find the cause.
// R15 - module_interrupt_n stays asserted while any unmasked flag is set and releases when all clear.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module mcs_control_status #(
  parameter int unsigned NUM_FLAGS   = mcs_pkg::NUM_FLAGS_DEF,
  parameter int unsigned INIT_CYCLES = mcs_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [mcs_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]                  wb_dat_i,
  input  wire logic [3:0]                   wb_sel_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Connector control pins
  input  wire logic                         module_reset_n,
  input  wire logic                         module_select_n,
  input  wire logic                         low_power_select,
  output logic                              module_interrupt_n,
  output logic                              module_present_n,
  // Serial management lines
  input  wire logic                         serialClk,
  input  wire logic                         serialData,
  // Optical side conditions
  input  wire logic                         rxSignalLoss,
  input  wire logic [NUM_FLAGS-1:1]         flagCondition,
  // Status outputs
  output logic                              lowPowerMode,
  output logic                              serialRespondEn,
  output logic                              irq
);
  import mcs_pkg::*;

  localparam int unsigned RST_W     = $clog2(RESET_MIN_CYCLES + 1);
  localparam int unsigned INIT_W    = $clog2(INIT_CYCLES + 1);
  localparam int          CLR_BOUND = 2;

  if (NUM_FLAGS < 2 || NUM_FLAGS > 8) begin : g_badFlags
    $error("NUM_FLAGS must be 2 to 8");
  end
  if (INIT_CYCLES < 2) begin : g_badInit
    $error("INIT_CYCLES must be at least 2");
  end

  mcs_state_t           state_r;
  logic [RST_W-1:0]     rstLowCnt_r;
  logic [INIT_W-1:0]    initCnt_r;
  logic                 pinResetValid;
  logic                 modEnter;
  logic                 readyPulse;
  logic                 dataNotReady_r;
  logic                 readyFlag_r;
  logic [NUM_FLAGS-1:0] flags_r;
  logic [NUM_FLAGS-1:0] flagMask_r;
  logic [NUM_FLAGS-1:0] condPrev_r;
  logic [NUM_FLAGS-1:0] flagCond;
  logic [NUM_FLAGS-1:0] flagRise;
  logic                 flagClr;
  logic                 ctrlPDown_r;
  logic [IRQ_W-1:0]     irqStat_r;
  logic [IRQ_W-1:0]     irqMask_r;
  logic [IRQ_W-1:0]     irqEvent;
  logic [IRQ_W-1:0]     irqClr;
  logic                 wbReq;
  logic                 wbWr;
  logic                 wbRd;
  logic                 hitStatus;
  logic                 hitFlags;
  logic                 hitMask;
  logic                 hitCtrl;
  logic                 hitIrqStat;
  logic                 hitIrqMask;
  logic [31:0]          rdData;
  logic                 refEdge;
  logic                 refRead;
  logic                 serialReadEnd;
  logic                 anyPending;

  // Reset pin qualification
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstLowCnt_r <= '0;
    end else if (module_reset_n) begin
      rstLowCnt_r <= '0;
    end else if (rstLowCnt_r != RST_W'(RESET_MIN_CYCLES)) begin
      rstLowCnt_r <= rstLowCnt_r + RST_W'(1);
    end
  end

  assign pinResetValid = rstLowCnt_r == RST_W'(RESET_MIN_CYCLES); // [R1]
  assign modEnter      = pinResetValid && state_r != ST_RESET;
  assign readyPulse    = state_r == ST_INIT && !pinResetValid && initCnt_r == INIT_W'(INIT_CYCLES - 1);

  // Power-on and reset sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_INIT;
      initCnt_r <= '0;
    end else begin
      case (state_r)
        ST_RESET: begin
          if (module_reset_n) begin
            state_r   <= ST_INIT; // [R4]
            initCnt_r <= '0;
          end
        end
        ST_INIT: begin
          if (pinResetValid) begin
            state_r <= ST_RESET; // [R1]
          end else if (readyPulse) begin
            state_r <= ST_READY; // [R4]
          end else begin
            initCnt_r <= initCnt_r + INIT_W'(1);
          end
        end
        ST_READY: begin
          if (pinResetValid) begin
            state_r <= ST_RESET; // [R1]
          end
        end
        default: begin
          state_r <= ST_RESET;
        end
      endcase
    end
  end

  // Data-not-ready status
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataNotReady_r <= 1'b1;
    end else if (modEnter) begin
      dataNotReady_r <= 1'b1;
    end else if (readyPulse) begin
      dataNotReady_r <= 1'b0; // [R2] [R3]
    end
  end

  // Readiness interrupt source, cleared by reading status; set wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readyFlag_r <= 1'b0;
    end else if (modEnter) begin
      readyFlag_r <= 1'b0;
    end else if (readyPulse) begin
      readyFlag_r <= 1'b1; // [R2] [R3]
    end else if ((wbRd && hitStatus) || serialReadEnd) begin
      readyFlag_r <= 1'b0;
    end
  end

  // Wishbone decode
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr  = wbReq && wb_we_i && wb_sel_i[0];
  assign wbRd  = wbReq && !wb_we_i;

  always_comb begin
    rdData     = '0;
    hitStatus  = 1'b0;
    hitFlags   = 1'b0;
    hitMask    = 1'b0;
    hitCtrl    = 1'b0;
    hitIrqStat = 1'b0;
    hitIrqMask = 1'b0;
    if (wb_adr_i == ADDR_STATUS) begin
      hitStatus                = 1'b1;
      rdData[STAT_NOT_READY]   = dataNotReady_r;
      rdData[STAT_LOW_POWER]   = lowPowerMode;
      rdData[STAT_RESPOND]     = serialRespondEn;
      rdData[STAT_READY_FLAG]  = readyFlag_r;
    end else if (wb_adr_i == ADDR_FLAGS) begin
      hitFlags                 = 1'b1;
      rdData[NUM_FLAGS-1:0]    = flags_r;
    end else if (wb_adr_i == ADDR_FLAG_MASK) begin
      hitMask                  = 1'b1;
      rdData[NUM_FLAGS-1:0]    = flagMask_r;
    end else if (wb_adr_i == ADDR_CONTROL) begin
      hitCtrl                  = 1'b1;
      rdData[CTRL_PDOWN]       = ctrlPDown_r;
    end else if (wb_adr_i == ADDR_IRQ_STATUS) begin
      hitIrqStat               = 1'b1;
      rdData[IRQ_W-1:0]        = irqStat_r;
    end else if (wb_adr_i == ADDR_IRQ_MASK) begin
      hitIrqMask               = 1'b1;
      rdData[IRQ_W-1:0]        = irqMask_r;
    end
  end

  // Single wait state answer, unmapped reads return zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbRd ? rdData : '0;
    end
  end

  // Flag mask and power-down control
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flagMask_r <= FLAG_MASK_RST[NUM_FLAGS-1:0];
    end else if (modEnter) begin
      flagMask_r <= FLAG_MASK_RST[NUM_FLAGS-1:0];
    end else if (wbWr && hitMask) begin
      flagMask_r <= wb_dat_i[NUM_FLAGS-1:0]; // [R10]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlPDown_r <= CTRL_PDOWN_RST;
    end else if (modEnter) begin
      ctrlPDown_r <= CTRL_PDOWN_RST;
    end else if (wbWr && hitCtrl) begin
      ctrlPDown_r <= wb_dat_i[CTRL_PDOWN]; // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowPowerMode <= 1'b1;
    end else begin
      lowPowerMode <= low_power_select || ctrlPDown_r; // [R6] [R12]
    end
  end

  // Serial bus gating and transaction end detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serialRespondEn <= 1'b0;
    end else begin
      serialRespondEn <= state_r == ST_READY && !module_select_n; // [R5] [R11]
    end
  end

  mcs_wire_watch u_watch (
    .clk     (ref_clk),
    .rst_n   (reset_n),
    .enable  (serialRespondEn),
    .scl     (serialClk),
    .sda     (serialData),
    .refEdge (refEdge),
    .refRead (refRead)
  );

  assign serialReadEnd = refEdge && refRead; // [R13] [R14]

  // Flag bits, one per condition; set wins over clear-on-read
  assign flagCond = {flagCondition, rxSignalLoss};
  assign flagRise = (state_r == ST_READY) ? (flagCond & ~condPrev_r) : '0;
  assign flagClr  = (wbRd && hitFlags) || serialReadEnd;

  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        condPrev_r[i] <= 1'b0;
        flags_r[i]    <= 1'b0;
      end else begin
        condPrev_r[i] <= flagCond[i];
        if (modEnter) begin
          flags_r[i] <= 1'b0;
        end else if (flagRise[i]) begin
          flags_r[i] <= 1'b1; // [R7] [R8]
        end else if (flagClr) begin
          flags_r[i] <= 1'b0; // [R9]
        end
      end
    end
  end

  // Interrupt pin
  assign anyPending = readyFlag_r || |(flags_r & ~flagMask_r);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_interrupt_n <= 1'b1;
    end else begin
      module_interrupt_n <= !anyPending; // [R7] [R9] [R10] [R15]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_present_n <= 1'b0;
    end else begin
      module_present_n <= 1'b0;
    end
  end

  // Internal event status, write one to clear, set wins
  assign irqEvent = {refEdge, modEnter, |flagRise, readyPulse};
  assign irqClr   = (wbWr && hitIrqStat) ? wb_dat_i[IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_r <= '0;
      irqMask_r <= IRQ_MASK_RST;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvent;
      if (wbWr && hitIrqMask) begin
        irqMask_r <= wb_dat_i[IRQ_W-1:0];
      end
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_resetPulse;
    pinResetValid && !module_reset_n |=> state_r == ST_RESET && dataNotReady_r;
  endproperty
  a_resetPulse: assert property (p_resetPulse) else $error("qualified reset pulse not taken"); // [R1]

  property p_readyReport;
    readyPulse |=> !dataNotReady_r && readyFlag_r ##1 !module_interrupt_n;
  endproperty
  a_readyReport: assert property (p_readyReport) else $error("ready not reported"); // [R2] [R3]

  sequence s_resetRelease;
    state_r == ST_RESET && module_reset_n;
  endsequence

  property p_resetRelease;
    s_resetRelease |=> state_r == ST_INIT && initCnt_r == '0 && dataNotReady_r;
  endproperty
  a_resetRelease: assert property (p_resetRelease) else $error("init not started after reset release"); // [R4]

  property p_noEarlyAnswer;
    state_r != ST_READY |=> !serialRespondEn;
  endproperty
  a_noEarlyAnswer: assert property (p_noEarlyAnswer) else $error("serial answer before ready"); // [R5]

  property p_lowPowerPin;
    low_power_select |=> lowPowerMode;
  endproperty
  a_lowPowerPin: assert property (p_lowPowerPin) else $error("low power pin ignored"); // [R6]

  property p_flagDrivesInt;
    |(flags_r & ~flagMask_r) |=> !module_interrupt_n;
  endproperty
  a_flagDrivesInt: assert property (p_flagDrivesInt) else $error("unmasked flag without interrupt"); // [R7]

  property p_rxLoss;
    state_r == ST_READY && rxSignalLoss && !condPrev_r[FLAG_RX_LOSS_BIT] && !modEnter
      |=> flags_r[FLAG_RX_LOSS_BIT];
  endproperty
  a_rxLoss: assert property (p_rxLoss) else $error("signal loss flag not set"); // [R8]

  sequence s_flagRead;
    wbRd && hitFlags && state_r == ST_READY && !readyFlag_r && flagRise == '0;
  endsequence

  property p_clearRelease;
    s_flagRead |-> ##[1:CLR_BOUND] module_interrupt_n;
  endproperty
  a_clearRelease: assert property (p_clearRelease) else $error("interrupt not released after read"); // [R9]

  property p_maskInhibit;
    !readyFlag_r && (flags_r & ~flagMask_r) == '0 |=> module_interrupt_n;
  endproperty
  a_maskInhibit: assert property (p_maskInhibit) else $error("masked flag drives interrupt"); // [R10] [R15]

  property p_selectGate;
    module_select_n |=> !serialRespondEn;
  endproperty
  a_selectGate: assert property (p_selectGate) else $error("answering while deselected"); // [R11]

  property p_powerDown;
    ctrlPDown_r |=> lowPowerMode;
  endproperty
  a_powerDown: assert property (p_powerDown) else $error("power down bit ignored"); // [R12]

  property p_intHeld;
    !module_interrupt_n |-> $past(anyPending);
  endproperty
  a_intHeld: assert property (p_intHeld) else $error("interrupt without a pending source"); // [R15]

endmodule

// *** bench/mcs_host_model.sv ***
`timescale 1ns/1ns
module mcs_host_model (
  // Clock
  input  wire logic ref_clk,
  // Connector pins
  output logic      module_reset_n,
  output logic      module_select_n,
  output logic      low_power_select,
  // Serial lines, data pulled up when released
  output logic      serialClk,
  output logic      serialData
);
  initial begin
    module_reset_n   = 1'b1;
    module_select_n  = 1'b1;
    low_power_select = 1'b0;
    serialClk        = 1'b1;
    serialData       = 1'b1;
  end

  task automatic set_select(input logic v);
    module_select_n <= v;
  endtask

  task automatic set_low_power(input logic v);
    low_power_select <= v;
  endtask

  task automatic hold_reset(input int n);
    @(posedge ref_clk);
    module_reset_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    module_reset_n <= 1'b1;
  endtask

  task automatic half(input logic c, input logic d);
    repeat (4) @(posedge ref_clk);
    serialClk  <= c;
    serialData <= d;
  endtask

  // Address byte, released ack slot, stop, then the reference fall
  task automatic serial_xfer(input logic [7:0] b);
    half(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      half(1'b0, b[i]);
      half(1'b1, b[i]);
    end
    half(1'b0, 1'b1);
    half(1'b1, 1'b1);
    half(1'b0, 1'b0);
    half(1'b1, 1'b0);
    half(1'b1, 1'b1);
    half(1'b0, 1'b1);
    half(1'b1, 1'b1);
  endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  import mcs_pkg::*;
  localparam int unsigned NF = 4;
  localparam int unsigned IC = 20;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          cyc     = 1'b0;
  logic          stb     = 1'b0;
  logic          we      = 1'b0;
  logic [7:0]    adr     = 8'h00;
  logic [31:0]   wdat    = 32'h0;
  logic [3:0]    sel     = 4'hF;
  logic [31:0]   rdat;
  logic          ack, mRst, mSel, lpSel, intN, presN, sClk, sDat;
  logic          rxLoss  = 1'b0;
  logic [NF-1:1] cond    = '0;
  logic          lowPwr, respEn, irq;
  logic [7:0]    regs [4] = '{ADDR_FLAG_MASK, ADDR_CONTROL, ADDR_IRQ_MASK, 8'h20};
  int            mismatches  = 0;
  int            checks_done = 0;

  always #25 ref_clk = ~ref_clk;

  mcs_host_model host (.ref_clk(ref_clk), .module_reset_n(mRst), .module_select_n(mSel),
    .low_power_select(lpSel), .serialClk(sClk), .serialData(sDat));

  mcs_control_status #(.NUM_FLAGS(NF), .INIT_CYCLES(IC)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .module_reset_n(mRst), .module_select_n(mSel),
    .low_power_select(lpSel), .module_interrupt_n(intN), .module_present_n(presN),
    .serialClk(sClk), .serialData(sDat), .rxSignalLoss(rxLoss), .flagCondition(cond),
    .lowPowerMode(lowPwr), .serialRespondEn(respEn), .irq(irq));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic wait_int(input logic lvl, input int lim);
    int n;
    n = 0;
    while (intN !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check(32'(intN), 32'(lvl));
  endtask

  initial begin
    cyc_n(2);
    reset_n <= 1'b1;
    host.set_select(1'b0);
    cyc_n(1);
    check(32'(presN), 32'h0);
    rd(ADDR_STATUS, 32'h1);
    foreach (regs[i]) rd(regs[i], 32'h0);
    wait_int(1'b0, IC + 10);
    rd(ADDR_STATUS, 32'hC);
    wait_int(1'b1, 5);
    rd(ADDR_IRQ_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1, 4'hF);
    cyc_n(1);
    check(32'(irq), 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1, 4'hF);
    cyc_n(1);
    check(32'(irq), 32'h0);
    rxLoss  <= 1'b1;
    cond[2] <= 1'b1;
    wait_int(1'b0, 3);
    rd(ADDR_FLAGS, 32'h5);
    wait_int(1'b1, 3);
    rd(ADDR_FLAGS, 32'h0);
    rxLoss <= 1'b0;
    cond   <= '0;
    wr(ADDR_FLAG_MASK, 32'h1, 4'hF);
    rxLoss <= 1'b1;
    cyc_n(4);
    check(32'(intN), 32'h1);
    rd(ADDR_FLAGS, 32'h1);
    wr(ADDR_FLAG_MASK, 32'h0, 4'hF);
    cond[1] <= 1'b1;
    wait_int(1'b0, 3);
    wr(ADDR_IRQ_MASK, 32'h8, 4'hF);
    host.serial_xfer(8'hA0);
    cyc_n(4);
    check(32'(intN), 32'h0);
    host.serial_xfer(8'hA1);
    wait_int(1'b1, 10);
    check(32'(irq), 32'h1);
    wr(ADDR_IRQ_STATUS, 32'hF, 4'hF);
    cyc_n(1);
    check(32'(irq), 32'h0);
    host.set_select(1'b1);
    cyc_n(3);
    check(32'(respEn), 32'h0);
    host.set_low_power(1'b1);
    cyc_n(2);
    check(32'(lowPwr), 32'h1);
    host.set_low_power(1'b0);
    cyc_n(2);
    check(32'(lowPwr), 32'h0);
    wr(ADDR_CONTROL, 32'h1, 4'hF);
    cyc_n(2);
    rd(ADDR_STATUS, 32'h2);
    wr(ADDR_CONTROL, 32'h0, 4'hE);
    cyc_n(2);
    check(32'(lowPwr), 32'h1);
    wr(ADDR_CONTROL, 32'h0, 4'hF);
    cyc_n(2);
    check(32'(lowPwr), 32'h0);
    host.hold_reset(100);
    cyc_n(3);
    rd(ADDR_STATUS, 32'h0);
    host.hold_reset(RESET_MIN_CYCLES + 5);
    rd(ADDR_STATUS, 32'h1);
    wait_int(1'b0, IC + 10);
    rd(ADDR_IRQ_STATUS, 32'h5);
    report_and_stop();
  end
endmodule
